// File: design/uft_bit_tick.sv
`timescale 1ns/1ps
module uft_bit_tick
  import uft_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);

  logic [27:0] acc;
  logic [27:0] next_acc;
  logic next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_acc = acc + UFT_ACC_STEP;
    if (next_acc >= UFT_ACC_WRAP) begin
      next_acc = next_acc - UFT_ACC_WRAP;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 28'h0000000;
      tick <= 1'b0;
    end else begin
      acc <= next_acc;
      tick <= next_tick;
    end
  end

  tick_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> !tick)
    else $error("bit tick pulse lasted more than one cycle");

endmodule

// File: design/uft_frame_count.sv
`timescale 1ns/1ps
module uft_frame_count
  import uft_pkg::*;
#(
  parameter int CNT_W = 14,
  parameter int SEQ_W = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic operational,
  input wire logic [CNT_W-1:0] frame_len,
  input wire logic toggle_in,
  input wire logic seq_wr,
  input wire logic [SEQ_W-1:0] seq_wdata,
  output logic [CNT_W-1:0] countdown,
  output logic toggle_copy,
  output logic [SEQ_W-1:0] seq,
  output logic load
);

  initial begin
    if (CNT_W < 2 || SEQ_W < 2) $error("uft_frame_count: widths too small");
  end

  logic oper_d;
  logic [CNT_W-1:0] next_countdown;
  logic next_toggle;
  logic [SEQ_W-1:0] next_seq;

  // Entering operation or reaching zero on a bit tick loads the frame
  assign load = (operational && !oper_d) ||
                (operational && tick && countdown == '0);

  always_comb begin
    next_countdown = countdown;
    next_toggle = toggle_copy;
    next_seq = seq;
    if (seq_wr) begin
      next_seq = seq_wdata;
    end
    if (load) begin
      next_countdown = frame_len;
      next_toggle = toggle_in;
      next_seq = seq + 1'b1;
    end else if (operational && tick) begin
      next_countdown = countdown - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oper_d <= 1'b0;
      countdown <= '0;
      toggle_copy <= 1'b0;
      seq <= '0;
    end else begin
      oper_d <= operational;
      countdown <= next_countdown;
      toggle_copy <= next_toggle;
      seq <= next_seq;
    end
  end

  sequence frame_end_s;
    operational && tick && countdown == '0 && oper_d;
  endsequence

  reload_value_a: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end_s |=> countdown == $past(frame_len))
    else $error("countdown did not reload at frame end");

  enter_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(operational) |=> countdown == $past(frame_len) && toggle_copy == $past(toggle_in))
    else $error("countdown not loaded on entering operation");

  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    operational && oper_d && tick && countdown != '0 |=> countdown == $past(countdown) - 1'b1)
    else $error("countdown did not step down on bit tick");

  count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !operational |=> countdown == $past(countdown))
    else $error("countdown moved outside operation");

  seq_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    load |=> seq == SEQ_W'($past(seq) + 1'b1))
    else $error("frame sequence did not advance with load");

  seq_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    load && seq == '1 |=> seq == '0)
    else $error("frame sequence did not wrap to zero");

  toggle_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    load |=> toggle_copy == $past(toggle_in))
    else $error("toggle copy not taken on load");

endmodule

// File: design/uft_frame_timing.sv
`timescale 1ns/1ps
module uft_frame_timing
  import uft_pkg::*;
#(
  parameter int CNT_W = 14,
  parameter int SEQ_W = 16,
  parameter int LS_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic frame_start,
  output logic periodic_go,
  output logic slow_start_ok,
  output logic [14:0] packet_budget,
  output logic operational
);

  initial begin
    if (CNT_W != 14 || SEQ_W != 16 || LS_W > CNT_W) begin
      $error("uft_frame_timing: unsupported widths");
    end
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return hit(a, UFT_OFF_BULK_CUR) || hit(a, UFT_OFF_DONE) ||
           hit(a, UFT_OFF_FM_CFG) || hit(a, UFT_OFF_TIME_LEFT) ||
           hit(a, UFT_OFF_FM_SEQ) || hit(a, UFT_OFF_PER_BEGIN) ||
           hit(a, UFT_OFF_SLOW_LIM) || hit(a, UFT_OFF_CTRL) ||
           hit(a, UFT_OFF_STATUS);
  endfunction

  function automatic logic read_only(input logic [7:0] a);
    return hit(a, UFT_OFF_TIME_LEFT) || hit(a, UFT_OFF_STATUS);
  endfunction

  uft_apb_req_t req;
  logic access;
  logic wr;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  assign access = req.sel && req.enable;
  assign wr = access && req.write && mapped(req.addr) && !read_only(req.addr);
  // Zero-wait slave; read-only writes and all unmapped accesses error
  assign pready = 1'b1;
  assign pslverr = access &&
                   (!mapped(req.addr) || (req.write && read_only(req.addr)));

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] bulk_current_list_pointer;
  logic [31:0] completed_list_head;
  logic [31:0] frame_length_config;
  logic [CNT_W-1:0] periodic_begin;
  logic [LS_W-1:0] slow_transfer_limit;
  logic [14:0] next_budget;
  logic [31:0] next_bulk;
  logic [31:0] next_done;
  logic [31:0] next_cfg;
  logic [CNT_W-1:0] next_per;
  logic [LS_W-1:0] next_slow;
  logic next_oper;
  logic [31:0] next_prdata;

  uft_frame_t fr;
  logic tick;
  logic load;
  logic seq_wr;

  assign seq_wr = wr && req.addr == UFT_OFF_FM_SEQ;

  always_comb begin
    next_bulk = bulk_current_list_pointer;
    next_done = completed_list_head;
    next_cfg = frame_length_config;
    next_per = periodic_begin;
    next_slow = slow_transfer_limit;
    next_oper = operational;
    if (wr) begin
      unique case (req.addr)
        UFT_OFF_BULK_CUR: next_bulk = req.wdata & UFT_PTR_MASK;
        UFT_OFF_DONE: next_done = req.wdata & UFT_PTR_MASK;
        UFT_OFF_FM_CFG: next_cfg = req.wdata & UFT_FM_CFG_MASK;
        UFT_OFF_PER_BEGIN: next_per = req.wdata[CNT_W-1:0];
        UFT_OFF_SLOW_LIM: next_slow = req.wdata[LS_W-1:0];
        UFT_OFF_CTRL: next_oper = req.wdata[0];
        default: next_oper = operational;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bulk_current_list_pointer <= 32'h00000000;
      completed_list_head <= 32'h00000000;
      frame_length_config <= UFT_FM_CFG_RST;
      periodic_begin <= '0;
      slow_transfer_limit <= '0;
      operational <= 1'b0;
    end else begin
      bulk_current_list_pointer <= next_bulk;
      completed_list_head <= next_done;
      frame_length_config <= next_cfg;
      periodic_begin <= next_per;
      slow_transfer_limit <= next_slow;
      operational <= next_oper;
    end
  end

  // ----------------------------------------
  // Frame counting
  // ----------------------------------------
  uft_bit_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // Toggle is software's to flip on each new length; hardware only copies it
  uft_frame_count #(.CNT_W(CNT_W), .SEQ_W(SEQ_W)) u_count (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .operational(operational),
    .frame_len(frame_length_config[CNT_W-1:0]),
    .toggle_in(frame_length_config[UFT_TOGGLE_BIT]),
    .seq_wr(seq_wr),
    .seq_wdata(req.wdata[SEQ_W-1:0]),
    .countdown(fr.countdown),
    .toggle_copy(fr.toggle_copy),
    .seq(fr.seq),
    .load(load)
  );

  // ----------------------------------------
  // Frame outputs
  // ----------------------------------------
  always_comb begin
    next_budget = packet_budget;
    if (load) begin
      next_budget = frame_length_config[UFT_PKT_MSB:UFT_PKT_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      packet_budget <= 15'h0000;
      frame_start <= 1'b0;
      periodic_go <= 1'b0;
      slow_start_ok <= 1'b0;
    end else begin
      packet_budget <= next_budget;
      frame_start <= load;
      periodic_go <= operational && fr.countdown <= periodic_begin;
      slow_start_ok <= operational &&
                       fr.countdown > CNT_W'(slow_transfer_limit);
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    next_prdata = 32'h00000000;
    if (req.sel && !req.enable && !req.write) begin
      unique case (req.addr)
        UFT_OFF_BULK_CUR: next_prdata = bulk_current_list_pointer;
        UFT_OFF_DONE: next_prdata = completed_list_head;
        UFT_OFF_FM_CFG: next_prdata = frame_length_config;
        UFT_OFF_TIME_LEFT: next_prdata = {fr.toggle_copy, 17'h00000, fr.countdown};
        UFT_OFF_FM_SEQ: next_prdata = {16'h0000, fr.seq};
        UFT_OFF_PER_BEGIN: next_prdata = {18'h00000, periodic_begin};
        UFT_OFF_SLOW_LIM: next_prdata = {20'h00000, slow_transfer_limit};
        UFT_OFF_CTRL: next_prdata = {31'h00000000, operational};
        UFT_OFF_STATUS: next_prdata = {13'h0000, periodic_go, slow_start_ok, packet_budget,
                                       frame_start, operational};
        default: next_prdata = 32'h00000000;
      endcase
    end else if (access) begin
      next_prdata = prdata;
    end
  end

  // Read data latched in setup so the countdown read is one snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= next_prdata;
    end
  end

  ptr_low_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    bulk_current_list_pointer[3:0] == 4'h0 && completed_list_head[3:0] == 4'h0)
    else $error("pointer low bits not zero");

  done_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && req.addr == UFT_OFF_DONE |=> completed_list_head == ($past(pwdata) & UFT_PTR_MASK))
    else $error("completed pointer write lost");

  budget_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    load |=> packet_budget == $past(frame_length_config[UFT_PKT_MSB:UFT_PKT_LSB]))
    else $error("packet budget not loaded at frame start");

  periodic_go_a: assert property (@(posedge pclk) disable iff (!presetn)
    operational && fr.countdown > periodic_begin |=> !periodic_go)
    else $error("periodic start raised early");

  // ----------------------------------------
  // Bus and frame output checks
  // ----------------------------------------
  // A read's setup cycle at one offset, then its access cycle
  sequence read_of_s(logic [7:0] off);
    psel && !penable && !pwrite && paddr == off ##1
    psel && penable && !pwrite;
  endsequence

  cfg_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
    frame_length_config[15:14] == 2'h0)
    else $error("frame length reserved bits set");

  bulk_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && req.addr == UFT_OFF_BULK_CUR |=> bulk_current_list_pointer == ($past(pwdata) & UFT_PTR_MASK))
    else $error("bulk cursor write lost");

  cfg_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && req.addr == UFT_OFF_FM_CFG |=> frame_length_config == ($past(pwdata) & UFT_FM_CFG_MASK))
    else $error("frame length write lost");

  begin_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && req.addr == UFT_OFF_PER_BEGIN |=> periodic_begin == $past(pwdata[CNT_W-1:0]))
    else $error("periodic begin write lost");

  cutoff_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && req.addr == UFT_OFF_SLOW_LIM |=> slow_transfer_limit == $past(pwdata[LS_W-1:0]))
    else $error("slow cutoff write lost");

  cursor_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    read_of_s(UFT_OFF_BULK_CUR) |-> prdata == $past(bulk_current_list_pointer))
    else $error("bulk cursor read wrong");

  cfg_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    read_of_s(UFT_OFF_FM_CFG) |-> prdata == $past(frame_length_config))
    else $error("frame length read wrong");

  left_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    read_of_s(UFT_OFF_TIME_LEFT) |->
      prdata == {$past(fr.toggle_copy), 17'h00000, $past(fr.countdown)})
    else $error("time left read wrong");

  seq_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    read_of_s(UFT_OFF_FM_SEQ) |-> prdata == {16'h0000, $past(fr.seq)})
    else $error("frame sequence read wrong");

  frame_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    load |=> frame_start)
    else $error("frame start pulse missing after load");

  periodic_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    operational && fr.countdown <= periodic_begin |=> periodic_go)
    else $error("periodic start not raised");

  slow_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    operational && fr.countdown <= CNT_W'(slow_transfer_limit) |=> !slow_start_ok)
    else $error("slow start allowed below cutoff");

  slow_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    operational && fr.countdown > CNT_W'(slow_transfer_limit) |=> slow_start_ok)
    else $error("slow start refused above cutoff");

  idle_outputs_a: assert property (@(posedge pclk) disable iff (!presetn)
    !operational |=> !periodic_go && !slow_start_ok)
    else $error("frame gates active outside operation");

  budget_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !load |=> packet_budget == $past(packet_budget))
    else $error("packet budget moved without load");

endmodule

// File: design/uft_pkg.sv
package uft_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] UFT_OFF_BULK_CUR = 8'h2c;
  localparam logic [7:0] UFT_OFF_DONE = 8'h30;
  localparam logic [7:0] UFT_OFF_FM_CFG = 8'h34;
  localparam logic [7:0] UFT_OFF_TIME_LEFT = 8'h38;
  localparam logic [7:0] UFT_OFF_FM_SEQ = 8'h3c;
  localparam logic [7:0] UFT_OFF_PER_BEGIN = 8'h40;
  localparam logic [7:0] UFT_OFF_SLOW_LIM = 8'h44;
  localparam logic [7:0] UFT_OFF_CTRL = 8'h50;
  localparam logic [7:0] UFT_OFF_STATUS = 8'h54;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int UFT_PTR_LSB = 4;
  localparam int UFT_TOGGLE_BIT = 31;
  localparam int UFT_PKT_LSB = 16;
  localparam int UFT_PKT_MSB = 30;
  localparam logic [13:0] UFT_FRAME_LEN_RST = 14'h2edf;
  localparam logic [31:0] UFT_FM_CFG_RST = 32'h00002edf;
  localparam logic [31:0] UFT_PTR_MASK = 32'hfffffff0;
  localparam logic [31:0] UFT_FM_CFG_MASK = 32'hffff3fff;

  // ----------------------------------------
  // Timing: 12 MHz bit time from 200 MHz pclk
  // ----------------------------------------
  localparam int UFT_PCLK_HZ = 200_000_000;
  localparam int UFT_BIT_HZ = 12_000_000;
  // Fractional accumulator: add BIT_HZ/1000, wrap at PCLK_HZ/1000, exact average rate
  localparam logic [27:0] UFT_ACC_STEP = 28'(UFT_BIT_HZ / 1000);
  localparam logic [27:0] UFT_ACC_WRAP = 28'(UFT_PCLK_HZ / 1000);

  typedef enum logic [1:0] {
    UFT_IDLE = 2'b00,
    UFT_RUN = 2'b01
  } uft_state_t;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } uft_apb_req_t;

  typedef struct packed {
    logic [13:0] countdown;
    logic toggle_copy;
    logic [15:0] seq;
  } uft_frame_t;

endpackage

// File: verification/tb.sv
`timescale 1ns/1ps
module tb
  import uft_pkg::*;
;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic err;
  } uft_row_t;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic frame_start;
  logic periodic_go;
  logic slow_start_ok;
  logic [14:0] packet_budget;
  logic operational;
  int n_fail = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic er;
  int cyc;

  // -------------------------------------------
  // Ordinary register cases: reset reads first
  // -------------------------------------------
  uft_row_t rows [14] = '{
    '{8'h2c, 1'b0, 32'h0, 32'h00000000, 1'b0},
    '{8'h30, 1'b0, 32'h0, 32'h00000000, 1'b0},
    '{8'h34, 1'b0, 32'h0, 32'h00002edf, 1'b0},
    '{8'h38, 1'b0, 32'h0, 32'h00000000, 1'b0},
    '{8'h3c, 1'b0, 32'h0, 32'h00000000, 1'b0},
    '{8'h40, 1'b0, 32'h0, 32'h00000000, 1'b0},
    '{8'h44, 1'b0, 32'h0, 32'h00000000, 1'b0},
    '{8'h2c, 1'b1, 32'hdeadbeef, 32'hdeadbee0, 1'b0},
    '{8'h30, 1'b1, 32'h1234567f, 32'h12345670, 1'b0},
    '{8'h34, 1'b1, 32'h8abcffff, 32'h8abc3fff, 1'b0},
    '{8'h38, 1'b1, 32'h0000ffff, 32'h00000000, 1'b1},
    '{8'h40, 1'b1, 32'h00002abc, 32'h00002abc, 1'b0},
    '{8'h44, 1'b1, 32'h00000fed, 32'h00000fed, 1'b0},
    '{8'h48, 1'b0, 32'h0, 32'h00000000, 1'b1}
  };

  uft_frame_timing uft_frame_timing_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .frame_start(frame_start),
    .periodic_go(periodic_go),
    .slow_start_ok(slow_start_ok),
    .packet_budget(packet_budget),
    .operational(operational)
  );

  always #2.5 pclk = ~pclk;

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        break;
      end
    end
    if (k == 50) begin
      n_fail++;
      $display("Error at %0t: bus timeout", $time);
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts edges until the next frame pulse; optional mid-frame checks
  task automatic wait_fs(input int bound, input logic probe, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (probe && n == 200) begin
        chk1(periodic_go, 1'b0);
        chk1(slow_start_ok, 1'b1);
      end
      if (probe && n == 450) begin
        chk1(periodic_go, 1'b1);
        chk1(slow_start_ok, 1'b0);
      end
      if (n > bound) begin
        n_fail++;
        $display("Error at %0t: no frame pulse", $time);
        conclude();
      end
    end while (frame_start !== 1'b1);
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk1(operational, 1'b0);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        apb(rows[i].addr, 1'b1, rows[i].wdata, rd, er);
        chk1(er, rows[i].err);
      end
      apb(rows[i].addr, 1'b0, 32'h0, rd, er);
      chk32(rd, rows[i].exp);
      // The write to a read-only word errors and reading it back is clean; the unmapped read errors
      chk1(er, rows[i].err && !rows[i].wr);
    end
    // -------------------------------------------
    // Short frames: 17 bit times, seq about to wrap
    // -------------------------------------------
    apb(8'h34, 1'b1, 32'h80050010, rd, er);
    apb(8'h3c, 1'b1, 32'h0000ffff, rd, er);
    apb(8'h40, 1'b1, 32'h00000008, rd, er);
    apb(8'h44, 1'b1, 32'h00000008, rd, er);
    apb(8'h50, 1'b1, 32'h00000001, rd, er);
    wait_fs(8, 1'b0, cyc);
    wait_fs(400, 1'b0, cyc);
    // Entry frame starts off the tick grid; time the next, tick-aligned one
    wait_fs(400, 1'b0, cyc);
    // 17 ticks at 12 MHz from 200 MHz: 283.3 cycles
    chk1(cyc >= 283 && cyc <= 284, 1'b1);
    chk32({17'h0, packet_budget}, 32'h00000005);
    apb(8'h3c, 1'b0, 32'h0, rd, er);
    chk32(rd, 32'h00000002);
    apb(8'h38, 1'b0, 32'h0, rd, er);
    chk1(rd[31], 1'b1);
    // -------------------------------------------
    // New length with toggle flipped, as software must
    // -------------------------------------------
    apb(8'h34, 1'b1, 32'h00070020, rd, er);
    wait_fs(400, 1'b0, cyc);
    wait_fs(700, 1'b1, cyc);
    chk1(cyc >= 549 && cyc <= 551, 1'b1);
    chk32({17'h0, packet_budget}, 32'h00000007);
    apb(8'h38, 1'b0, 32'h0, rd, er);
    chk1(rd[31], 1'b0);
    apb(8'h3c, 1'b0, 32'h0, rd, er);
    chk32(rd, 32'h00000004);
    // -------------------------------------------
    // Leaving operational: countdown must freeze
    // -------------------------------------------
    apb(8'h50, 1'b1, 32'h00000000, rd, er);
    repeat (4) @(posedge pclk);
    apb(8'h38, 1'b0, 32'h0, rd, er);
    repeat (100) @(posedge pclk);
    apb(8'h38, 1'b0, 32'h0, rd2, er);
    chk32(rd2, rd);
    chk1(operational, 1'b0);
    chk1(periodic_go, 1'b0);
    chk1(slow_start_ok, 1'b0);
    // Re-entry reloads at once, no wait for the old count
    apb(8'h50, 1'b1, 32'h00000001, rd, er);
    wait_fs(8, 1'b0, cyc);
    apb(8'h38, 1'b0, 32'h0, rd, er);
    chk1(rd[13:0] <= 14'h0020 && rd[13:0] >= 14'h001e, 1'b1);
    conclude();
  end
endmodule
